/* dv/cgs_top_tb.sv */
`default_nettype none
module cgs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    cgs_pkg::cgs_clk_status_t clk_status;
    logic stop_mode;
    cgs_pkg::cgs_clk_ctrl_t clk_ctrl;
    logic lost_lock_irq;
    logic monitor_reset_req;
    int bad_count = 0;
    int samples_checked = 0;

    cgs_top i_cgs_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .clk_status(clk_status), .stop_mode(stop_mode),
        .clk_ctrl(clk_ctrl), .lost_lock_irq(lost_lock_irq), .monitor_reset_req(monitor_reset_req)
    );

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Outputs are registered, so the value at a negedge is the one sampled at the next posedge
    task automatic wait_ready(output logic [31:0] rd);
        logic rdy;
        for (int i = 0; i < 50; i++) begin
            @(negedge hclk);
            rdy = hreadyout;
            rd = hrdata;
            @(posedge hclk);
            if (rdy === 1'b1) begin
                return;
            end
        end
        bad_count++;
        $display("MISMATCH hreadyout expected 1 seen timeout");
        complete_run();
    endtask : wait_ready

    task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] rd);
        logic [31:0] dummy;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_ready(dummy);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h00000000;
        wait_ready(rd);
    endtask : ahb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb_xfer(a, 1'b1, d, rd);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] rd;
        ahb_xfer(a, 1'b0, 32'h00000000, rd);
        check(name, exp & mask, rd & mask);
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        rd_chk("pll_control", cgs_pkg::ADDR_PLL, 32'hffffffff, 32'h00000001);
        rd_chk("mode", cgs_pkg::ADDR_MODE, 32'hffffffff, 32'h00000004);
        rd_chk("trim", cgs_pkg::ADDR_TRIM, 32'hffffffff, 32'h00000080);
        rd_chk("unmapped", 8'h40, 32'hffffffff, 32'h00000000);
        check("hresp", 32'h0, {31'h0, hresp});
        check("ctrl trim", {24'h0, cgs_pkg::TRIM_RST}, {24'h0, clk_ctrl.trim});
        check("ctrl ref select", {31'h0, cgs_pkg::REFSEL_RST}, {31'h0, clk_ctrl.ref_select});
        check("ctrl ref divider", {29'h0, cgs_pkg::REF_DIVIDER_RST}, {29'h0, clk_ctrl.ref_divider});
        check("ctrl fll enable", 32'h1, {31'h0, clk_ctrl.fll_enable});
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_vco_table;
        logic [31:0] exp;
        for (int c = 0; c < 16; c++) begin
            exp = (c == 0) ? 32'h0 : (c > 10) ? 32'h28 : 32'(4 * c);
            wr(cgs_pkg::ADDR_PLL, 32'(c));
            // Multiplier lands one edge after the code register
            idle(1);
            rd_chk("vco_mult", cgs_pkg::ADDR_MULT, 32'h0000003f, exp);
        end
        wr(cgs_pkg::ADDR_PLL, 32'h00000001);
        $display("test vco_table done");
    endtask : t_vco_table

    task automatic t_status_sync;
        for (int m = 0; m < 4; m++) begin
            clk_status.clk_mode <= cgs_pkg::cgs_clk_mode_t'(m[1:0]);
            clk_status.loop_src <= m[0];
            clk_status.ref_src <= m[1];
            idle(6);
            rd_chk("mode status", cgs_pkg::ADDR_STATUS, 32'h0000000c, 32'(m << 2));
            rd_chk("loop status", cgs_pkg::ADDR_STATUS, 32'h00000020, {26'h0, m[0], 5'h0});
            rd_chk("ref status", cgs_pkg::ADDR_STATUS, 32'h00000010, {27'h0, m[1], 4'h0});
        end
        clk_status.clk_mode <= cgs_pkg::CGS_MODE_FLL;
        clk_status.loop_src <= 1'b0;
        clk_status.ref_src <= 1'b1;
        $display("test status_sync done");
    endtask : t_status_sync

    task automatic t_lock;
        clk_status.fll_locked <= 1'b1;
        idle(25);
        rd_chk("lock", cgs_pkg::ADDR_STATUS, 32'h00000040, 32'h00000040);
        wr(cgs_pkg::ADDR_TRIM, 32'h00000081);
        idle(2);
        rd_chk("lock after trim", cgs_pkg::ADDR_STATUS, 32'h00000040, 32'h0);
        idle(25);
        rd_chk("relock", cgs_pkg::ADDR_STATUS, 32'h00000040, 32'h00000040);
        stop_mode <= 1'b1;
        idle(4);
        rd_chk("lock in stop", cgs_pkg::ADDR_STATUS, 32'h00000040, 32'h0);
        stop_mode <= 1'b0;
        idle(25);
        wr(cgs_pkg::ADDR_MODE, 32'h00000105);
        idle(25);
        rd_chk("lock low power", cgs_pkg::ADDR_STATUS, 32'h00000040, 32'h0);
        check("ctrl low power", 32'h5, {29'h0, clk_ctrl.low_power, clk_ctrl.clock_select});
        wr(cgs_pkg::ADDR_MODE, 32'h00000004);
        idle(25);
        rd_chk("lock after exit", cgs_pkg::ADDR_STATUS, 32'h00000040, 32'h00000040);
        $display("test lock done");
    endtask : t_lock

    task automatic t_sticky_irq;
        wr(cgs_pkg::ADDR_PLL, 32'h00000081);
        clk_status.fll_locked <= 1'b0;
        idle(6);
        rd_chk("sticky", cgs_pkg::ADDR_STATUS, 32'h00000080, 32'h00000080);
        check("irq", 32'h1, {31'h0, lost_lock_irq});
        wr(cgs_pkg::ADDR_PLL, 32'h00000001);
        idle(2);
        check("irq masked", 32'h0, {31'h0, lost_lock_irq});
        wr(cgs_pkg::ADDR_STATUS, 32'h00000000);
        rd_chk("sticky write 0", cgs_pkg::ADDR_STATUS, 32'h00000080, 32'h00000080);
        wr(cgs_pkg::ADDR_STATUS, 32'h00000080);
        idle(1);
        rd_chk("sticky cleared", cgs_pkg::ADDR_STATUS, 32'h00000080, 32'h0);
        $display("test sticky_irq done");
    endtask : t_sticky_irq

    task automatic t_osc_flag;
        clk_status.osc_done <= 1'b1;
        wr(cgs_pkg::ADDR_MODE, 32'h00000044);
        idle(6);
        rd_chk("osc no enable", cgs_pkg::ADDR_STATUS, 32'h00000002, 32'h0);
        wr(cgs_pkg::ADDR_MODE, 32'h000000c4);
        idle(6);
        rd_chk("osc set", cgs_pkg::ADDR_STATUS, 32'h00000002, 32'h00000002);
        check("ctrl osc request", 32'h3, {30'h0, clk_ctrl.oscillator_request, clk_ctrl.ext_ref_enable});
        wr(cgs_pkg::ADDR_MODE, 32'h00000084);
        idle(2);
        rd_chk("osc cleared", cgs_pkg::ADDR_STATUS, 32'h00000002, 32'h0);
        wr(cgs_pkg::ADDR_MODE, 32'h00000004);
        $display("test osc_flag done");
    endtask : t_osc_flag

    task automatic t_controls;
        wr(cgs_pkg::ADDR_STATUS, 32'h00000001);
        idle(2);
        rd_chk("fine trim", cgs_pkg::ADDR_STATUS, 32'h00000001, 32'h00000001);
        check("fine trim out", 32'h1, {31'h0, clk_ctrl.fine_trim_bit});
        wr(cgs_pkg::ADDR_PLL, 32'h00000041);
        idle(2);
        check("pll enable", 32'h1, {30'h0, clk_ctrl.fll_enable, clk_ctrl.pll_enable});
        wr(cgs_pkg::ADDR_PLL, 32'h00000001);
        idle(2);
        check("fll enable", 32'h2, {30'h0, clk_ctrl.fll_enable, clk_ctrl.pll_enable});
        clk_status.ext_clk_lost <= 1'b1;
        idle(5);
        check("monitor off", 32'h0, {31'h0, monitor_reset_req});
        // Monitor goes on with the monitor enable bit alone; the external reference is enabled here as well
        wr(cgs_pkg::ADDR_MODE, 32'h00000084);
        wr(cgs_pkg::ADDR_PLL, 32'h00000021);
        idle(5);
        check("monitor on", 32'h1, {31'h0, monitor_reset_req});
        $display("test controls done");
    endtask : t_controls

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        clk_status = '{default: 1'b0, ref_src: 1'b1, clk_mode: cgs_pkg::CGS_MODE_FLL};
        stop_mode = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_vco_table();
        t_status_sync();
        t_lock();
        t_sticky_irq();
        t_osc_flag();
        t_controls();
        complete_run();
    end
endmodule : cgs_top_tb
`default_nettype wire

/* include/cgs_pkg.sv */
`default_nettype none
package cgs_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_PLL = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_TRIM = 8'h0c;
    localparam logic [7:0] ADDR_MULT = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STS_STICKY_BIT = 7;
    localparam int STS_LOCK_BIT = 6;
    localparam int STS_LOOP_BIT = 5;
    localparam int STS_REF_BIT = 4;
    localparam int STS_MODE_LSB = 2;
    localparam int STS_OSC_BIT = 1;
    localparam int STS_FINE_TRIM_BIT_BIT = 0;
    localparam int PLL_IRQEN_BIT = 7;
    localparam int PLL_SEL_BIT = 6;
    localparam int PLL_CME_BIT = 5;
    localparam int PLL_VCO_LSB = 0;
    localparam int MODE_CS_LSB = 0;
    localparam int MODE_REFSEL_BIT = 2;
    localparam int MODE_REF_DIVIDER_LSB = 3;
    localparam int MODE_OSCREQ_BIT = 6;
    localparam int MODE_EXTEN_BIT = 7;
    localparam int MODE_LP_BIT = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] VCO_RST = 4'h1;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic REFSEL_RST = 1'b1;
    localparam logic [2:0] REF_DIVIDER_RST = 3'h0;

    // ------------------------------------------------------------
    // Multiplier and lock qualification
    // ------------------------------------------------------------
    localparam logic [3:0] VCO_CODE_MAX = 4'ha;
    localparam logic [5:0] VCO_STEP = 6'h04;
    localparam logic [4:0] LOCK_QUAL_CYCLES = 5'h10;
    localparam int SYNC_W = 8;

    typedef enum logic [1:0] {
        CGS_MODE_FLL = 2'b00,
        CGS_MODE_IREF = 2'b01,
        CGS_MODE_EREF = 2'b10,
        CGS_MODE_PLL = 2'b11
    } cgs_clk_mode_t;

    // Status arriving from the generator's own clock domains
    typedef struct packed {
        logic fll_locked;
        logic pll_locked;
        logic osc_done;
        logic ext_clk_lost;
        logic loop_src;
        logic ref_src;
        cgs_clk_mode_t clk_mode;
    } cgs_clk_status_t;

    // Controls driven to the rest of the clock unit
    typedef struct packed {
        cgs_clk_mode_t clock_select;
        logic ref_select;
        logic [2:0] ref_divider;
        logic [7:0] trim;
        logic fine_trim_bit;
        logic oscillator_request;
        logic ext_ref_enable;
        logic low_power;
        logic loop_select;
        logic fll_enable;
        logic pll_enable;
        logic [5:0] vco_mult;
    } cgs_clk_ctrl_t;
endpackage : cgs_pkg
`default_nettype wire

/* verilog/cgs_lock.sv */
`default_nettype none
module cgs_lock (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Loop state
    input wire logic detect_en,
    input wire logic locked_in,
    input wire logic disturb,
    // Results
    output logic lock_o,
    output logic lost_o
);
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic lock_reg;
    logic lock_next;
    logic hold_off;

    // ------------------------------------------------------------
    // Lock qualification
    // ------------------------------------------------------------
    // Raw lock must hold for a while so a glitch cannot fake relock
    always_comb begin
        hold_off = disturb | !detect_en | !locked_in;
        cnt_next = cnt_reg;
        if (hold_off) begin
            cnt_next = 5'h00;
        end else if (cnt_reg != cgs_pkg::LOCK_QUAL_CYCLES) begin
            cnt_next = cnt_reg + 5'h01;
        end
        lock_next = !hold_off && (lock_reg || cnt_reg == cgs_pkg::LOCK_QUAL_CYCLES);
        lost_o = lock_reg && detect_en && !locked_in && !disturb;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 5'h00;
            lock_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            lock_reg <= lock_next;
        end
    end

    assign lock_o = lock_reg;
endmodule : cgs_lock
`default_nettype wire

/* verilog/cgs_sync.sv */
`default_nettype none
module cgs_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : cgs_sync
`default_nettype wire

/* verilog/cgs_top.sv */
`default_nettype none
// How it works
// - Writes changing reference, loop, divider, active trim or VCO code clear lock.
// - Lock shows in status bit 6; detection is off when both loops off.
// - Entering stop clears lock until the active loop relocks.
// - Entering a low-power bypass mode clears lock until it is left and relocked.
// - Bit 5 shows loop actually feeding the clock path, after synchronisation.
// - Bit 4 shows reference in use, after synchronisation.
// - Bits 3:2 show current clock mode, after synchronisation.
// - Oscillator flag sets after start-up when requested and external reference enabled or selected.
// - Oscillator flag clears on dropped request or internal mode without enable.
// - Fine trim bit 0 lengthens period when set, shortens when clear.
// - Interrupt enable bit 7 lets the sticky lost flag request an interrupt.
// - Loop select picks PLL or FLL and disables the other in every mode.
// - Monitor enable bit 5 makes external clock loss request reset.
// - VCO code gives factor four times code, capped at 40.
// - Sticky lost flag sets on lost lock; write 1 clears, 0 ignored.
// - Oscillator request is required for the flag whichever reference is selected.
module cgs_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clock unit side
    input wire cgs_pkg::cgs_clk_status_t clk_status,
    input wire logic stop_mode,
    output cgs_pkg::cgs_clk_ctrl_t clk_ctrl,
    output logic lost_lock_irq,
    output logic monitor_reset_req
);
    // ------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------
    logic dp_wr_reg, dp_wr_next;
    logic [7:0] dp_addr_reg, dp_addr_next;
    logic [31:0] hrdata_next;
    logic addr_ok;
    logic wr_status, wr_pll, wr_mode, wr_trim;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic irq_en_reg, irq_en_next;
    logic cme_reg, cme_next;
    logic [3:0] vco_reg, vco_next;
    logic [7:0] trim_reg, trim_next;
    logic fine_trim_bit_reg, fine_trim_bit_next;
    logic [8:0] mode_reg, mode_next;

    // ------------------------------------------------------------
    // Hardware state
    // ------------------------------------------------------------
    logic sticky_reg, sticky_next;
    logic osc_reg, osc_next;
    logic stop_prev_reg, lp_prev_reg;
    logic irq_next, rst_req_next;
    cgs_pkg::cgs_clk_ctrl_t ctrl_next;
    cgs_pkg::cgs_clk_status_t sts_sync;
    cgs_pkg::cgs_clk_mode_t cs;
    logic ref_sel, loop_sel, lp_mode, fll_int, pll_ext, disturb;
    logic lock_w, lost_w, osc_keep;
    logic [7:0] status_byte;

    cgs_sync #(
        .W(cgs_pkg::SYNC_W)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .async_in(clk_status),
        .sync_out(sts_sync)
    );

    // Lock is judged only while the chosen loop is really enabled
    cgs_lock u_lock (
        .clk(hclk),
        .rst_n(hresetn),
        .detect_en(clk_ctrl.fll_enable | clk_ctrl.pll_enable),
        .locked_in(loop_sel ? sts_sync.pll_locked : sts_sync.fll_locked),
        .disturb(disturb),
        .lock_o(lock_w),
        .lost_o(lost_w)
    );

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Zero wait states; unmapped reads give zero, writes there are dropped
    always_comb begin
        addr_ok = hsel && hready && htrans[1];
        dp_wr_next = addr_ok && hwrite;
        dp_addr_next = addr_ok ? haddr[7:0] : 8'hff;
        hrdata_next = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                cgs_pkg::ADDR_STATUS: hrdata_next = {24'h00_0000, status_byte};
                cgs_pkg::ADDR_PLL: hrdata_next = {24'h00_0000, irq_en_reg, loop_sel, cme_reg, 1'b0, vco_reg};
                cgs_pkg::ADDR_MODE: hrdata_next = {23'h00_0000, mode_reg};
                cgs_pkg::ADDR_TRIM: hrdata_next = {24'h00_0000, trim_reg};
                cgs_pkg::ADDR_MULT: hrdata_next = {26'h000_0000, clk_ctrl.vco_mult};
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
        wr_status = dp_wr_reg && dp_addr_reg == cgs_pkg::ADDR_STATUS;
        wr_pll = dp_wr_reg && dp_addr_reg == cgs_pkg::ADDR_PLL;
        wr_mode = dp_wr_reg && dp_addr_reg == cgs_pkg::ADDR_MODE;
        wr_trim = dp_wr_reg && dp_addr_reg == cgs_pkg::ADDR_TRIM;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 8'hff;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_wr_reg <= dp_wr_next;
            dp_addr_reg <= dp_addr_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register writes and mode decode
    // ------------------------------------------------------------
    always_comb begin
        irq_en_next = wr_pll ? hwdata[cgs_pkg::PLL_IRQEN_BIT] : irq_en_reg;
        cme_next = wr_pll ? hwdata[cgs_pkg::PLL_CME_BIT] : cme_reg;
        vco_next = wr_pll ? hwdata[cgs_pkg::PLL_VCO_LSB +: 4] : vco_reg;
        fine_trim_bit_next = wr_status ? hwdata[cgs_pkg::STS_FINE_TRIM_BIT_BIT] : fine_trim_bit_reg;
        trim_next = wr_trim ? hwdata[7:0] : trim_reg;
        mode_next = mode_reg;
        if (wr_mode) begin
            mode_next = hwdata[8:0];
        end
        if (wr_pll) begin
            mode_next[cgs_pkg::MODE_LP_BIT] = mode_reg[cgs_pkg::MODE_LP_BIT];
        end
        cs = cgs_pkg::cgs_clk_mode_t'(mode_reg[cgs_pkg::MODE_CS_LSB +: 2]);
        ref_sel = mode_reg[cgs_pkg::MODE_REFSEL_BIT];
        loop_sel = clk_ctrl.loop_select;
        lp_mode = mode_reg[cgs_pkg::MODE_LP_BIT]
            && ((cs == cgs_pkg::CGS_MODE_IREF && ref_sel) || (cs == cgs_pkg::CGS_MODE_EREF && !ref_sel));
        fll_int = ref_sel && !loop_sel && !lp_mode && (cs == cgs_pkg::CGS_MODE_FLL || cs == cgs_pkg::CGS_MODE_IREF);
        pll_ext = !ref_sel && loop_sel && !lp_mode && (cs == cgs_pkg::CGS_MODE_FLL || cs == cgs_pkg::CGS_MODE_EREF);
        // Any retune of the loop invalidates the old lock
        disturb = (wr_mode && (hwdata[cgs_pkg::MODE_REFSEL_BIT] != ref_sel
                || hwdata[cgs_pkg::MODE_REF_DIVIDER_LSB +: 3] != mode_reg[cgs_pkg::MODE_REF_DIVIDER_LSB +: 3]))
            || (wr_pll && hwdata[cgs_pkg::PLL_SEL_BIT] != loop_sel)
            || (wr_trim && fll_int && hwdata[7:0] != trim_reg)
            || (wr_pll && pll_ext && hwdata[cgs_pkg::PLL_VCO_LSB +: 4] != vco_reg)
            || (stop_mode && !stop_prev_reg)
            || (lp_mode && !lp_prev_reg);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_reg <= 1'b0;
            cme_reg <= 1'b0;
            vco_reg <= cgs_pkg::VCO_RST;
            fine_trim_bit_reg <= 1'b0;
            trim_reg <= cgs_pkg::TRIM_RST;
            mode_reg <= {6'h00, cgs_pkg::REFSEL_RST, 2'b00};
        end else begin
            irq_en_reg <= irq_en_next;
            cme_reg <= cme_next;
            vco_reg <= vco_next;
            fine_trim_bit_reg <= fine_trim_bit_next;
            trim_reg <= trim_next;
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // Flags and outputs
    // ------------------------------------------------------------
    always_comb begin
        status_byte = {sticky_reg, lock_w, sts_sync.loop_src, sts_sync.ref_src,
            sts_sync.clk_mode, osc_reg, fine_trim_bit_reg};
        // Set beats a simultaneous write-one clear
        sticky_next = lost_w || (sticky_reg && !(wr_status && hwdata[cgs_pkg::STS_STICKY_BIT]));
        // Set needs the keep condition and start-up done; clear needs only the keep condition to fail
        osc_keep = mode_reg[cgs_pkg::MODE_OSCREQ_BIT]
            && (mode_reg[cgs_pkg::MODE_EXTEN_BIT] || !ref_sel);
        osc_next = osc_keep && (osc_reg || sts_sync.osc_done);
        irq_next = sticky_reg && irq_en_reg;
        rst_req_next = cme_reg && sts_sync.ext_clk_lost;
        ctrl_next.clock_select = cs;
        ctrl_next.ref_select = ref_sel;
        ctrl_next.ref_divider = mode_reg[cgs_pkg::MODE_REF_DIVIDER_LSB +: 3];
        ctrl_next.trim = trim_reg;
        ctrl_next.fine_trim_bit = fine_trim_bit_reg;
        ctrl_next.oscillator_request = mode_reg[cgs_pkg::MODE_OSCREQ_BIT];
        ctrl_next.ext_ref_enable = mode_reg[cgs_pkg::MODE_EXTEN_BIT];
        ctrl_next.low_power = mode_reg[cgs_pkg::MODE_LP_BIT];
        ctrl_next.loop_select = wr_pll ? hwdata[cgs_pkg::PLL_SEL_BIT] : loop_sel;
        ctrl_next.fll_enable = !ctrl_next.loop_select && !lp_mode && !stop_mode;
        ctrl_next.pll_enable = ctrl_next.loop_select && !lp_mode && !stop_mode;
        if (vco_reg > cgs_pkg::VCO_CODE_MAX) begin
            ctrl_next.vco_mult = 6'(cgs_pkg::VCO_STEP * cgs_pkg::VCO_CODE_MAX);
        end else begin
            ctrl_next.vco_mult = 6'(cgs_pkg::VCO_STEP * vco_reg);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sticky_reg <= 1'b0;
            osc_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
            lp_prev_reg <= 1'b0;
            lost_lock_irq <= 1'b0;
            monitor_reset_req <= 1'b0;
            clk_ctrl <= '0;
        end else begin
            sticky_reg <= sticky_next;
            osc_reg <= osc_next;
            stop_prev_reg <= stop_mode;
            lp_prev_reg <= lp_mode;
            lost_lock_irq <= irq_next;
            monitor_reset_req <= rst_req_next;
            clk_ctrl <= ctrl_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_disturb_drops_lock: assert property (disturb |=> !lock_w)
        else $error("lock survived a retune");
    a_lock_needs_loop: assert property (!(clk_ctrl.fll_enable || clk_ctrl.pll_enable) |=> !lock_w)
        else $error("lock shown with both loops off");
    a_stop_clears_lock: assert property ($rose(stop_mode) |=> !lock_w [*2])
        else $error("lock not cleared on stop entry");
    a_lp_holds_lock: assert property (lp_mode && lp_prev_reg |=> !lock_w)
        else $error("lock shown in low-power bypass");
    a_loop_status_sync: assert property ($rose(clk_status.loop_src) |-> ##2 sts_sync.loop_src)
        else $error("loop status not synchronised in two cycles");
    // Synchroniser flops start at zero, so the first two edges after reset are skipped
    a_ref_status_sync: assert property ($past(hresetn, 2) |-> sts_sync.ref_src == $past(clk_status.ref_src, 2))
        else $error("reference status wrong");
    a_mode_status_sync: assert property ($past(hresetn, 2) |->
        sts_sync.clk_mode == $past(clk_status.clk_mode, 2))
        else $error("mode status not two cycles behind");
    a_osc_flag_set: assert property (osc_keep && sts_sync.osc_done |=> osc_reg)
        else $error("oscillator flag not set");
    a_osc_flag_clear: assert property (!mode_reg[cgs_pkg::MODE_OSCREQ_BIT] |=> !osc_reg)
        else $error("oscillator flag held without request");
    a_irq_follows: assert property (sticky_reg && irq_en_reg |=> lost_lock_irq)
        else $error("interrupt missing");
    a_irq_masked: assert property (!irq_en_reg |=> !lost_lock_irq)
        else $error("interrupt with enable clear");
    a_loops_exclusive: assert property (clk_ctrl.loop_select |-> !clk_ctrl.fll_enable)
        else $error("both loops enabled");
    a_monitor_gate: assert property (!cme_reg |=> !monitor_reset_req)
        else $error("reset request with monitor off");
    a_mult_capped: assert property (vco_reg >= 4'ha |=> clk_ctrl.vco_mult == 6'h28)
        else $error("multiplier not capped at 40");
    a_sticky_holds: assert property (sticky_reg && !wr_status |=> sticky_reg)
        else $error("sticky flag lost");
    a_sticky_sets: assert property (lost_w |=> sticky_reg)
        else $error("sticky flag missed a lost lock");
    a_osc_flag_drop: assert property (!osc_keep |=> !osc_reg)
        else $error("oscillator flag held without its condition");
endmodule : cgs_top
`default_nettype wire
